//--- verilog/rog_gate.sv
// Random octet gate: raw-bit health tests, octet packing, gated output
`timescale 1ns/1ps
`default_nettype none
module rog_gate
    import rog_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic raw_valid,
    input wire logic raw_bit,
    input wire logic retest,
    output logic rnd_valid,
    input wire logic rnd_ready,
    output logic [rog_pkg::ROG_OCTET_W-1:0] rnd_octet,
    output logic test_pass,
    output logic test_fail
);
    rog_state_t state_r, state_nxt;
    logic [ROG_CNT_W-1:0] bitcnt_r, bitcnt_nxt;
    logic [ROG_CNT_W-1:0] ones_r, ones_nxt;
    logic [ROG_RUN_W-1:0] run_r, run_nxt;
    logic last_r, last_nxt;
    logic [ROG_OCTET_W-1:0] sh_r, sh_nxt;
    logic [2:0] nb_r, nb_nxt;
    logic oct_v_r, oct_v_nxt;
    logic pass_r, pass_nxt;
    logic fail_r, fail_nxt;
    logic win_end, stuck, ones_bad, f_valid, f_flush, out_en, take_bit;
    logic [ROG_OCTET_W-1:0] f_data;
    logic [ROG_CNT_W-1:0] ones_now;

    ////////////////////////////////////////////////////////////////////////
    // Raw bit accepted only outside the lock-out
    function automatic logic bit_taken(input logic vld, input rog_state_t st);
        return vld && (st != ROG_ST_FAIL);
    endfunction

    // Window length per phase; start-up and periodic may differ
    // Both must stay a multiple of the octet width to keep octets aligned
    function automatic int window_len(input rog_state_t st);
        return (st == ROG_ST_STARTUP) ? ROG_STARTUP_BITS : ROG_WINDOW_BITS;
    endfunction

    // Shared by the health tests and the packer so both see the same bits
    assign take_bit = bit_taken(raw_valid, state_r);

    ////////////////////////////////////////////////////////////////////////
    // Health test counters and verdict
    always_comb begin
        state_nxt = state_r;
        bitcnt_nxt = bitcnt_r;
        ones_nxt = ones_r;
        run_nxt = run_r;
        last_nxt = last_r;
        pass_nxt = pass_r;
        fail_nxt = fail_r;
        ones_now = ones_r + ROG_CNT_W'(raw_bit);
        win_end = 1'b0;
        stuck = 1'b0;
        ones_bad = 1'b0;
        if (take_bit) begin
            // Window counting from the first bit
            last_nxt = raw_bit;
            if (bitcnt_r != '0 && raw_bit == last_r) begin
                run_nxt = run_r + 1'b1;
            end else begin
                run_nxt = '0;
            end
            // Run count restarts with each window, so a window start never trips it
            stuck = (32'(run_r) + 1 >= ROG_RUN_LIMIT) && bitcnt_r != '0
                && raw_bit == last_r;
            win_end = (32'(bitcnt_r) + 1 == window_len(state_r));
            ones_bad = win_end && (32'(ones_now) < ROG_ONES_LO
                || 32'(ones_now) > ROG_ONES_HI);
            if (win_end) begin
                bitcnt_nxt = '0;
                ones_nxt = '0;
            end else begin
                bitcnt_nxt = bitcnt_r + 1'b1;
                ones_nxt = ones_now;
            end
            if (stuck || ones_bad) begin
                // Defect: lock up and drop verdict at once
                state_nxt = ROG_ST_FAIL;
                pass_nxt = 1'b0;
                fail_nxt = 1'b1;
            end else if (win_end) begin
                // Pass is granted only at window end
                state_nxt = ROG_ST_RUN;
                pass_nxt = 1'b1;
            end
        end
        // Retest leaves the lock-out and starts a fresh start-up window
        if (retest && state_r == ROG_ST_FAIL) begin
            state_nxt = ROG_ST_STARTUP;
            fail_nxt = 1'b0;
            bitcnt_nxt = '0;
            ones_nxt = '0;
            run_nxt = '0;
        end
    end

    // Health state registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_r <= ROG_ST_STARTUP;
            bitcnt_r <= '0;
            ones_r <= '0;
            run_r <= '0;
            last_r <= 1'b0;
            pass_r <= ROG_PASS_RST;
            fail_r <= ROG_FAIL_RST;
        end else begin
            state_r <= state_nxt;
            bitcnt_r <= bitcnt_nxt;
            ones_r <= ones_nxt;
            run_r <= run_nxt;
            last_r <= last_nxt;
            pass_r <= pass_nxt;
            fail_r <= fail_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Octet packer; a full FIFO drops whole octets, the tests still see every bit
    always_comb begin
        sh_nxt = sh_r;
        nb_nxt = nb_r;
        oct_v_nxt = 1'b0;
        if (take_bit) begin
            sh_nxt = {sh_r[ROG_OCTET_W-2:0], raw_bit};
            nb_nxt = nb_r + 3'h1;
            oct_v_nxt = (nb_r == 3'h7);
        end
        // Defect drops the partial octet
        if (f_flush) begin
            nb_nxt = '0;
            oct_v_nxt = 1'b0;
        end
    end

    // Packer registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            sh_r <= '0;
            nb_r <= '0;
            oct_v_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            nb_r <= nb_nxt;
            oct_v_r <= oct_v_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flush buffered octets on any defect so none escape
    // Taken from the next state so the defect bit's own edge already clears
    assign f_flush = (state_nxt == ROG_ST_FAIL);
    // Output opens only in run after a passed window
    assign out_en = pass_r && state_r == ROG_ST_RUN && !f_flush;

    // Four-word buffer between packer and output
    rog_fifo #(.WIDTH(ROG_OCTET_W), .DEPTH(ROG_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .flush(f_flush),
        .in_valid(oct_v_r),
        .in_ready(), // Full FIFO drops octets
        .in_data(sh_r),
        .out_valid(f_valid),
        .out_ready(out_en && (!rnd_valid || rnd_ready)),
        .out_data(f_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered output stage
    logic rv_r, rv_nxt;
    logic [ROG_OCTET_W-1:0] ro_r, ro_nxt;
    // Next output: load when empty or being taken
    always_comb begin
        rv_nxt = rv_r;
        ro_nxt = ro_r;
        if (rnd_ready) begin
            rv_nxt = 1'b0;
        end
        if (out_en && f_valid && (!rv_r || rnd_ready)) begin
            rv_nxt = 1'b1;
            ro_nxt = f_data;
        end
        // A defect empties the output in the same edge
        if (f_flush) begin
            rv_nxt = 1'b0;
        end
    end

    // Output registers
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rv_r <= 1'b0;
            ro_r <= '0;
        end else begin
            rv_r <= rv_nxt;
            ro_r <= ro_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ports straight from registers
    assign rnd_valid = rv_r;
    assign rnd_octet = ro_r;
    assign test_pass = pass_r;
    assign test_fail = fail_r;
endmodule
`default_nettype wire

//--- verilog/rog_pkg.sv
// Package of constants for the random octet gate with online health test
package rog_pkg;
    localparam int ROG_OCTET_W = 8;
    localparam int ROG_FIFO_DEPTH = 4;
    // Start-up test window in raw bits
    localparam int ROG_STARTUP_BITS = 1024;
    // Periodic test window in raw bits
    localparam int ROG_WINDOW_BITS = 1024;
    localparam int ROG_CNT_W = 11;
    // Repetition limit: longest tolerated run of equal raw bits
    localparam int ROG_RUN_LIMIT = 32;
    localparam int ROG_RUN_W = 6;
    // Monobit bounds over one window (ones count)
    localparam int ROG_ONES_LO = 448;
    localparam int ROG_ONES_HI = 576;
    // Reset values
    localparam logic ROG_PASS_RST = 1'b0;
    localparam logic ROG_FAIL_RST = 1'b0;
    typedef enum logic [1:0] {ROG_ST_STARTUP, ROG_ST_RUN, ROG_ST_FAIL} rog_state_t;
endpackage

//--- verilog/rog_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rog_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic [WIDTH-1:0] dout_r, dout_nxt;
    logic push, pop;

    ////////////////////////////////////////////////////////////////////////
    // Next state of pointers and storage
    always_comb begin
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        mem_nxt = mem_r;
        if (push) begin
            mem_nxt[wp_r] = in_data;
            wp_nxt = AW'((32'(wp_r) + 1) % DEPTH);
        end
        if (pop) begin
            rp_nxt = AW'((32'(rp_r) + 1) % DEPTH);
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        if (flush) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
        end
        dout_nxt = mem_nxt[rp_nxt];
    end

    assign in_ready = (32'(cnt_r) < DEPTH);
    assign out_valid = (cnt_r != '0);
    assign out_data = dout_r;

    // Register stage; read data comes from a register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            dout_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            dout_r <= dout_nxt;
        end
        mem_r <= mem_nxt;
    end
endmodule
`default_nettype wire

//--- dv/rog_gate_chk.sv
// Port checker for the random octet gate
`timescale 1ns/1ps
`default_nettype none
module rog_gate_chk
    import rog_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic raw_valid,
    input wire logic retest,
    input wire logic rnd_valid,
    input wire logic rnd_ready,
    input wire logic [rog_pkg::ROG_OCTET_W-1:0] rnd_octet,
    input wire logic test_pass,
    input wire logic test_fail
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // Offered octet left waiting
    sequence s_stall;
        rnd_valid && !rnd_ready;
    endsequence
    a_gate_out: assert property (rnd_valid |-> test_pass && !test_fail)
        else $error("octet offered without pass");
    a_hold_valid: assert property (s_stall |=> rnd_valid || test_fail)
        else $error("octet withdrawn while stalled");
    a_hold_octet: assert property (s_stall |=> test_fail || $stable(rnd_octet))
        else $error("octet changed while stalled");
    a_fail_holds: assert property (test_fail |=> test_fail || $past(retest))
        else $error("defect flag dropped");
    a_pass_holds: assert property ($fell(test_pass) |-> test_fail)
        else $error("pass dropped without defect");
    a_pass_cause: assert property ($rose(test_pass) |-> $past(raw_valid) || $past(raw_valid, 2))
        else $error("pass without raw bit");
    a_fail_cause: assert property ($rose(test_fail) |-> $past(raw_valid) || $past(raw_valid, 2))
        else $error("defect without raw bit");
    a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !test_pass && !rnd_valid)
        else $error("outputs set after reset");
endmodule
bind rog_gate rog_gate_chk u_chk (.core_clk(core_clk), .rst_b(rst_b), .raw_valid(raw_valid),
    .retest(retest),
    .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .rnd_octet(rnd_octet),
    .test_pass(test_pass), .test_fail(test_fail));
`default_nettype wire

//--- dv/rog_gate_tb.sv
// Self-checking bench for the random octet gate
`timescale 1ns/1ps
`default_nettype none
module rog_gate_tb;
    import rog_pkg::*;
    logic core_clk, rst_b, raw_valid, raw_bit, retest, rnd_valid, rnd_ready, test_pass, test_fail;
    logic [ROG_OCTET_W-1:0] rnd_octet;
    int miscompares = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic ph = 1'b1;
    rog_gate DUT (.core_clk(core_clk), .rst_b(rst_b), .raw_valid(raw_valid), .raw_bit(raw_bit),
        .retest(retest), .rnd_valid(rnd_valid), .rnd_ready(rnd_ready), .rnd_octet(rnd_octet),
        .test_pass(test_pass), .test_fail(test_fail));
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic check(string nm, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle(int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Raw bits: 0 alternating, 1 stuck high, 2 one in four
    task automatic send(int n, int mode);
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            raw_valid <= 1'b1;
            raw_bit <= (mode == 0) ? ph : (mode == 1) ? 1'b1 : (i % 4 == 0);
            ph = ~ph;
        end
        @(posedge core_clk);
        raw_valid <= 1'b0;
    endtask
    task automatic retest_pulse();
        @(posedge core_clk);
        retest <= 1'b1;
        @(posedge core_clk);
        retest <= 1'b0;
        idle(2);
    endtask
    task automatic t_startup();
        check("pass rst", 8'h00, test_pass);
        send(1023, 0);
        idle(3);
        check("pass early", 8'h00, test_pass);
        check("valid early", 8'h00, rnd_valid);
        send(1, 0);
        idle(3);
        check("pass", 8'h01, test_pass);
        check("valid", 8'h01, rnd_valid);
        check("first octet", 8'hAA, rnd_octet);
    endtask
    task automatic t_octets();
        int got = 0;
        send(48, 0);
        idle(12);
        while (rnd_valid === 1'b1 && got < 8) begin
            check("octet", 8'hAA, rnd_octet);
            got++;
            rnd_ready <= 1'b1;
            @(posedge core_clk);
            rnd_ready <= 1'b0;
            idle(4);
        end
        check("kept", 8'h01, got == ROG_FIFO_DEPTH + 1);
        rnd_ready <= 1'b1;
        send(1104, 0);
        idle(12);
        check("pass kept", 8'h01, test_pass);
        rnd_ready <= 1'b0;
    endtask
    task automatic t_stuck();
        send(16, 0);
        idle(12);
        check("queued", 8'h01, rnd_valid);
        send(34, 1);
        idle(2);
        check("stuck", 8'h01, test_fail);
        check("blocked", 8'h00, rnd_valid);
        check("pass off", 8'h00, test_pass);
        send(64, 0);
        idle(12);
        check("still off", 8'h00, rnd_valid);
    endtask
    task automatic t_bias();
        retest_pulse();
        check("cleared", 8'h00, test_fail);
        send(1024, 2);
        idle(3);
        check("bias", 8'h01, test_fail);
        retest_pulse();
        send(1024, 0);
        idle(3);
        check("pass again", 8'h01, test_pass);
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 9000) begin
            miscompares++;
            close_out();
        end
    end
    initial begin
        rst_b = 1'b0;
        raw_valid = 1'b0;
        raw_bit = 1'b0;
        retest = 1'b0;
        rnd_ready = 1'b0;
        idle(20);
        rst_b <= 1'b1;
        idle(1);
        t_startup();
        t_octets();
        t_stuck();
        t_bias();
        close_out();
    end
endmodule
`default_nettype wire
